// >>> include/clk_synth_pkg.sv
// Functional notes
// - Decode three-bit spread code into mode/percent.
// - Byte 6 read-only revision and vendor signature.
// - Nine-bit multiplier in bytes 7 and 8.
// - Seven-bit divider in byte 9 bits 7:1.
// - Byte 9 bit 0 selects ROM or registers.
// - Strap pair selects fixed scaling constant.
// - 48 MHz outputs and dual output in phase.
// - Early-PCI straps select PCI advance offset.
// - PCI stop input halts non-free-running PCI outputs.
// - Byte 0 bit 5 picks 48M or 66M.
// - Dual output mode follows byte 0 bit 5 at any time.
// - Active-low CPU stop affects only CPU pairs.
// - Stop after two falling CPU edges sampled.
// - Stopped pair: true high, complement low.
// - Restart synchronously without runt or stretched pulse.
// - Restart within three complement clock cycles.
// - Per-pair bit: one free running, zero stoppable.
// - Byte 4 bit 7 top spread bit, byte 5.
// - Config bit tri-states CPU outputs during stop.
package clk_synth_pkg;

  // ------------------------------------------------------------
  // Register indices
  // ------------------------------------------------------------
  localparam logic [3:0] IDX_CTRL0     = 4'h0;
  localparam logic [3:0] IDX_CPU_CTRL  = 4'h1;
  localparam logic [3:0] IDX_OUT66     = 4'h4;
  localparam logic [3:0] IDX_SPREAD    = 4'h5;
  localparam logic [3:0] IDX_SIGNATURE = 4'h6;
  localparam logic [3:0] IDX_MULT_HIGH = 4'h7;
  localparam logic [3:0] IDX_MULT_LOW  = 4'h8;
  localparam logic [3:0] IDX_DIV_SRC   = 4'h9;

  // ------------------------------------------------------------
  // Reset values
  // ------------------------------------------------------------
  localparam logic [7:0] RST_CTRL0     = 8'h00;
  localparam logic [7:0] RST_CPU_CTRL  = 8'h07;
  localparam logic [7:0] RST_OUT66     = 8'h3F;
  localparam logic [7:0] RST_SPREAD    = 8'h40;
  localparam logic [7:0] RST_MULT_HIGH = 8'h0E;
  localparam logic [7:0] RST_MULT_LOW  = 8'h00;
  localparam logic [7:0] RST_DIV_SRC   = 8'h00;

  // Signature nibbles: arbitrary neutral values
  localparam logic [3:0] SIG_REVISION  = 4'h3;
  localparam logic [3:0] SIG_VENDOR    = 4'h5;

  // ------------------------------------------------------------
  // Field positions
  // ------------------------------------------------------------
  localparam int BIT_DUAL_48M   = 5;
  localparam int BIT_CPU_TRI    = 6;
  localparam int BIT_FREE_LO    = 3;
  localparam int BIT_SPREAD_TOP = 7;
  localparam int BIT_SPREAD_MID = 7;
  localparam int BIT_SPREAD_LOW = 6;
  localparam int BIT_MULT_MSB   = 0;
  localparam int BIT_SRC_SEL    = 0;
  localparam int NUM_CPU_PAIRS  = 3;
  localparam int STOP_QUAL_EDGES = 2;

  // Scaling constants per strap code
  localparam logic [26:0] SCALE_00 = 27'd32005333;
  localparam logic [26:0] SCALE_01 = 27'd48008000;
  localparam logic [26:0] SCALE_10 = 27'd96016000;
  localparam logic [26:0] SCALE_11 = 27'd64010667;

  // Early-PCI advance in picoseconds
  localparam logic [10:0] EPCI_ADV_00 = 11'd0;
  localparam logic [10:0] EPCI_ADV_10 = 11'd800;
  localparam logic [10:0] EPCI_ADV_11 = 11'd1600;

  // Spread modes
  typedef enum logic {SPREAD_DOWN, SPREAD_CENTER} spread_mode_e;

endpackage

// >>> rtl/clock_synth_ctrl_stop_logic.sv
`timescale 1ns/1ps
// ------------------------------------------------------------
// Control logic: registers, strap decode and CPU stop
// ------------------------------------------------------------
module clock_synth_ctrl_stop_logic
  import clk_synth_pkg::*;
#(
  parameter logic [8:0] ROM_MULT = 9'h000,
  parameter logic [6:0] ROM_DIV  = 7'h00
) (
  // Clocks and reset
  input  wire logic        clk_sys,
  input  wire logic        nrst,
  input  wire logic        cpu_clk,
  // Byte register port
  input  wire logic [3:0]  reg_idx,
  input  wire logic        reg_wr,
  input  wire logic [7:0]  reg_wdata,
  output logic      [7:0]  reg_rdata,
  // Straps
  input  wire logic [1:0]  freq_strap,
  input  wire logic        early_pci_strap_hi,
  input  wire logic        early_pci_strap_lo,
  // Stop inputs
  input  wire logic        cpu_halt_n,
  input  wire logic        pci_halt_n,
  // Synth control
  output logic [8:0]       mult_eff,
  output logic [6:0]       div_eff,
  output logic [26:0]      scale_const,
  output logic [10:0]      pci_adv_ps,
  output logic [2:0]       spread_code,
  output logic             spread_center,
  output logic [7:0]       spread_up,
  output logic [7:0]       spread_down,
  output logic             dual_is_48m,
  output logic             dual_spread_en,
  output logic             align_48m,
  output logic             pci_run,
  // CPU pairs
  output logic [2:0]       cpu_stopped,
  output logic [2:0]       cpu_tri
);

  // ------------------------------------------------------------
  // Reset release
  // ------------------------------------------------------------
  logic rst_s1_reg;   // First release stage
  logic rst_n;        // Released reset copy
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      rst_s1_reg <= 1'b0;
      rst_n      <= 1'b0;
    end else begin
      rst_s1_reg <= 1'b1;
      rst_n      <= rst_s1_reg;
    end
  end

  // ------------------------------------------------------------
  // Control bytes
  // ------------------------------------------------------------
  logic [7:0] ctrl0_reg;     // Byte 0
  logic [7:0] cpu_ctrl_reg;  // Byte 1
  logic [7:0] out66_reg;     // Byte 4
  logic [7:0] spread_reg;    // Byte 5
  logic [7:0] mult_hi_reg;   // Byte 7
  logic [7:0] mult_lo_reg;   // Byte 8
  logic [7:0] div_src_reg;   // Byte 9

  wire wr_ctrl0   = reg_wr && reg_idx == IDX_CTRL0;
  wire wr_cpu     = reg_wr && reg_idx == IDX_CPU_CTRL;
  wire wr_out66   = reg_wr && reg_idx == IDX_OUT66;
  wire wr_spread  = reg_wr && reg_idx == IDX_SPREAD;
  wire wr_mult_hi = reg_wr && reg_idx == IDX_MULT_HIGH;
  wire wr_mult_lo = reg_wr && reg_idx == IDX_MULT_LOW;
  wire wr_div     = reg_wr && reg_idx == IDX_DIV_SRC;

  // Byte 6 has no write path at all
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      ctrl0_reg    <= RST_CTRL0;
      cpu_ctrl_reg <= RST_CPU_CTRL;
      out66_reg    <= RST_OUT66;
      spread_reg   <= RST_SPREAD;
      mult_hi_reg  <= RST_MULT_HIGH;
      mult_lo_reg  <= RST_MULT_LOW;
      div_src_reg  <= RST_DIV_SRC;
    end else begin
      if (wr_ctrl0)   ctrl0_reg    <= reg_wdata;
      if (wr_cpu)     cpu_ctrl_reg <= reg_wdata;
      if (wr_out66)   out66_reg    <= reg_wdata;
      if (wr_spread)  spread_reg   <= reg_wdata;
      // Reserved bits keep power-up value
      if (wr_mult_hi) mult_hi_reg  <= {RST_MULT_HIGH[7:1],
                                       reg_wdata[0]};
      if (wr_mult_lo) mult_lo_reg  <= reg_wdata;
      if (wr_div)     div_src_reg  <= reg_wdata;
    end
  end

  // ------------------------------------------------------------
  // Read mux
  // ------------------------------------------------------------
  logic [7:0] rd_mux;   // Selected byte
  always_comb begin
    unique case (reg_idx)
      IDX_CTRL0:     rd_mux = ctrl0_reg;
      IDX_CPU_CTRL:  rd_mux = cpu_ctrl_reg;
      IDX_OUT66:     rd_mux = out66_reg;
      IDX_SPREAD:    rd_mux = spread_reg;
      IDX_SIGNATURE: rd_mux = {SIG_REVISION, SIG_VENDOR};
      IDX_MULT_HIGH: rd_mux = mult_hi_reg;
      IDX_MULT_LOW:  rd_mux = mult_lo_reg;
      IDX_DIV_SRC:   rd_mux = div_src_reg;
      default:       rd_mux = 8'h00;   // Unmapped bytes read zero
    endcase
  end

  // ------------------------------------------------------------
  // Derived control
  // ------------------------------------------------------------
  wire [8:0] mult_bus = {mult_hi_reg[BIT_MULT_MSB], mult_lo_reg};
  wire [6:0] div_bus  = div_src_reg[7:1];
  wire       use_bus  = div_src_reg[BIT_SRC_SEL];
  wire [8:0] mult_sel = use_bus ? mult_bus : ROM_MULT;
  wire [6:0] div_sel  = use_bus ? div_bus  : ROM_DIV;

  wire [2:0] sp_code = {out66_reg[BIT_SPREAD_TOP],
                        spread_reg[BIT_SPREAD_MID],
                        spread_reg[BIT_SPREAD_LOW]};
  spread_mode_e sp_mode;   // Decoded mode
  logic [7:0]   sp_up;     // Upward spread
  logic [7:0]   sp_down;   // Downward spread
  spread_decode u_spread (
    .code     (sp_code),
    .mode     (sp_mode),
    .up_pct   (sp_up),
    .down_pct (sp_down)
  );

  // Straps captured after reset release, once
  logic        strap_done_reg;  // Straps caught
  logic [1:0]  fs_reg;          // Frequency straps
  logic [1:0]  epci_reg;        // Early-PCI straps
  logic        dual_mode_reg;   // Mode copied from byte 0 every cycle
  logic [26:0] scale_next;
  logic [10:0] adv_next;
  always_comb begin
    unique case (fs_reg)
      2'b00: scale_next = SCALE_00;
      2'b01: scale_next = SCALE_01;
      2'b10: scale_next = SCALE_10;
      2'b11: scale_next = SCALE_11;
    endcase
  end
  // Code 01 is not listed; treated as no advance
  always_comb begin
    unique case (epci_reg)
      2'b10:   adv_next = EPCI_ADV_10;
      2'b11:   adv_next = EPCI_ADV_11;
      default: adv_next = EPCI_ADV_00;
    endcase
  end

  // Dual mode follows byte 0 bit 5 every cycle, 0->1 and 1->0 alike (may glitch)
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      strap_done_reg <= 1'b0;
      fs_reg         <= 2'b00;
      epci_reg       <= 2'b00;
      dual_mode_reg  <= 1'b0;
    end else begin
      if (!strap_done_reg) begin
        fs_reg   <= freq_strap;
        epci_reg <= {early_pci_strap_hi, early_pci_strap_lo};
      end
      strap_done_reg <= 1'b1;
      dual_mode_reg  <= ctrl0_reg[BIT_DUAL_48M];
    end
  end

  // ------------------------------------------------------------
  // CPU pairs
  // ------------------------------------------------------------
  logic [2:0] pair_stop;   // Per-pair stop state
  logic [2:0] pair_tri;    // Per-pair tri-state
  genvar g;
  generate
    for (g = 0; g < NUM_CPU_PAIRS; g++) begin : g_pair
      cpu_pair_gate u_gate (
        .cpu_clk  (cpu_clk),
        .rst_n    (rst_n),
        .halt_req (~cpu_halt_n),
        .free_run (cpu_ctrl_reg[BIT_FREE_LO + g]),
        .tri_mode (cpu_ctrl_reg[BIT_CPU_TRI]),
        .stopped  (pair_stop[g]),
        .tri_out  (pair_tri[g])
      );
    end
  endgenerate

  // ------------------------------------------------------------
  // Stop status into the system clock
  // ------------------------------------------------------------
  logic [2:0] stop_sync_reg;  // First stage of stop status
  logic [2:0] tri_sync_reg;   // First stage of tri-state status
  // Bits cross one by one; a cycle of skew between pairs is harmless
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      stop_sync_reg <= 3'b000;
      tri_sync_reg  <= 3'b000;
    end else begin
      stop_sync_reg <= pair_stop;
      tri_sync_reg  <= pair_tri;
    end
  end

  // ------------------------------------------------------------
  // Output registers
  // ------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata      <= 8'h00;
      mult_eff       <= 9'h000;
      div_eff        <= 7'h00;
      scale_const    <= SCALE_00;
      pci_adv_ps     <= EPCI_ADV_00;
      spread_code    <= 3'b000;
      spread_center  <= 1'b0;
      spread_up      <= 8'h00;
      spread_down    <= 8'h00;
      dual_is_48m    <= 1'b0;
      dual_spread_en <= 1'b1;
      align_48m      <= 1'b0;
      pci_run        <= 1'b1;
      cpu_stopped    <= 3'b000;
      cpu_tri        <= 3'b000;
    end else begin
      reg_rdata      <= rd_mux;
      mult_eff       <= mult_sel;
      div_eff        <= div_sel;
      scale_const    <= scale_next;
      pci_adv_ps     <= adv_next;
      spread_code    <= sp_code;
      spread_center  <= sp_mode == SPREAD_CENTER;
      spread_up      <= sp_up;
      spread_down    <= sp_down;
      dual_is_48m    <= dual_mode_reg;
      dual_spread_en <= ~dual_mode_reg;
      align_48m      <= dual_mode_reg;
      pci_run        <= pci_halt_n;
      cpu_stopped    <= stop_sync_reg;
      cpu_tri        <= tri_sync_reg;
    end
  end

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  a_sig_fixed: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    reg_idx == IDX_SIGNATURE |=> reg_rdata == {SIG_REVISION, SIG_VENDOR})
    else $error("signature byte wrong");
  a_resv_hold: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    mult_hi_reg[7:1] == RST_MULT_HIGH[7:1])
    else $error("reserved bits changed");
  // One cycle of ROM select is enough for the registered copies
  a_src_rom: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    !use_bus |=> mult_eff == ROM_MULT && div_eff == ROM_DIV)
    else $error("rom source not used");
  // Source must stay on the bus across the two-cycle path
  a_mult_path: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    wr_mult_lo && use_bus ##1 use_bus
      |=> mult_eff[7:0] == $past(reg_wdata, 2))
    else $error("multiplier low not applied");
  a_div_apply: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    wr_div && reg_wdata[BIT_SRC_SEL] ##1 !wr_div
      |=> div_eff == $past(reg_wdata[7:1], 2))
    else $error("divider not applied");
  a_dual_nospr: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    dual_is_48m |-> !dual_spread_en && align_48m)
    else $error("48M mode with spread");
  a_dual_follow: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    ctrl0_reg[BIT_DUAL_48M] |-> ##2 dual_is_48m)
    else $error("dual mode not applied");
  a_spread_ctr: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    out66_reg[BIT_SPREAD_TOP] |-> ##1 spread_center)
    else $error("center spread not chosen");
  a_pci_stop: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    !pci_halt_n |=> !pci_run)
    else $error("pci not stopped");
  a_pci_go: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    pci_halt_n |=> pci_run)
    else $error("pci not restarted");
  a_scale_map: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    strap_done_reg && fs_reg == 2'b10 |=> scale_const == SCALE_10)
    else $error("scale constant wrong");

endmodule

// >>> rtl/cpu_pair_gate.sv
`timescale 1ns/1ps
// ------------------------------------------------------------
// One CPU pair stop gate on the CPU clock domain
// ------------------------------------------------------------
module cpu_pair_gate
  import clk_synth_pkg::*;
(
  // Clock and reset
  input  wire logic cpu_clk,
  input  wire logic rst_n,
  // Control
  input  wire logic halt_req,
  input  wire logic free_run,
  input  wire logic tri_mode,
  // Outputs
  output logic      stopped,
  output logic      tri_out
);

  logic halt_s1_reg;   // Synchroniser stage one
  logic halt_s2_reg;   // Synchroniser stage two
  logic stop_reg;      // Pair held in stop

  // Two falling edges: s1 then s2, only s2 is examined
  always_ff @(negedge cpu_clk or negedge rst_n) begin
    if (!rst_n) begin
      halt_s1_reg <= 1'b0;
      halt_s2_reg <= 1'b0;
    end else begin
      halt_s1_reg <= halt_req;
      halt_s2_reg <= halt_s1_reg;
    end
  end

  // Stop changes only at a falling edge, so no runt pulse
  always_ff @(negedge cpu_clk or negedge rst_n) begin
    if (!rst_n) begin
      stop_reg <= 1'b0;
    end else begin
      stop_reg <= halt_s2_reg & ~free_run;
    end
  end

  assign stopped = stop_reg;
  assign tri_out = stop_reg & tri_mode;

  a_stop_lag: assert property (
    @(negedge cpu_clk) disable iff (!rst_n)
    halt_s2_reg && !free_run |=> stop_reg)
    else $error("pair not stopped after qualification");
  a_free_runs: assert property (
    @(negedge cpu_clk) disable iff (!rst_n)
    $past(free_run) && free_run |-> !stop_reg)
    else $error("free running pair stopped");
  a_restart_bnd: assert property (
    @(negedge cpu_clk) disable iff (!rst_n)
    !halt_req |-> ##[1:3] !stop_reg)
    else $error("restart too slow");

endmodule

// >>> rtl/spread_decode.sv
`timescale 1ns/1ps
// ------------------------------------------------------------
// Spread code decode to mode and percentage in hundredths
// ------------------------------------------------------------
module spread_decode
  import clk_synth_pkg::*;
(
  // Code
  input  wire logic [2:0] code,
  // Decoded
  output spread_mode_e    mode,
  output logic [7:0]      up_pct,
  output logic [7:0]      down_pct
);

  // Percentages in hundredths of a percent
  assign mode = code[2] ? SPREAD_CENTER : SPREAD_DOWN;
  always_comb begin
    up_pct   = 8'h00;
    down_pct = 8'h00;
    unique case (code)
      3'b000: down_pct = 8'd25;
      3'b001: down_pct = 8'd50;
      3'b010: down_pct = 8'd75;
      3'b011: down_pct = 8'd100;
      3'b100: begin up_pct = 8'd13; down_pct = 8'd13; end
      3'b101: begin up_pct = 8'd25; down_pct = 8'd25; end
      3'b110: begin up_pct = 8'd37; down_pct = 8'd37; end
      3'b111: begin up_pct = 8'd50; down_pct = 8'd150; end
    endcase
  end

endmodule

// >>> test/clock_synth_ctrl_stop_logic_tb.sv
`timescale 1ns/1ps
// ------------------------------------------------------------
// Self-checking bench for the synth control block
// ------------------------------------------------------------
module clock_synth_ctrl_stop_logic_tb;
  import clk_synth_pkg::*;
  logic        clk_sys, nrst, cpu_clk, reg_wr;
  logic [3:0]  reg_idx;
  logic [7:0]  reg_wdata, reg_rdata, rv;
  logic [1:0]  freq_strap;
  logic        early_pci_strap_hi, early_pci_strap_lo;
  logic        cpu_halt_n, pci_halt_n;
  logic [8:0]  mult_eff;
  logic [6:0]  div_eff;
  logic [26:0] scale_const;
  logic [10:0] pci_adv_ps;
  logic [2:0]  spread_code, cpu_stopped, cpu_tri;
  logic [7:0]  spread_up, spread_down;
  logic        spread_center, dual_is_48m, dual_spread_en;
  logic        align_48m, pci_run;
  int          error_cnt, check_count, cyc;

  // ------------------------------------------------------------
  // Clocks: CPU clock unrelated in phase to the system clock
  // ------------------------------------------------------------
  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end
  initial begin
    cpu_clk = 1'b0;
    #1.3;
    forever #3.5 cpu_clk = ~cpu_clk;
  end

  clock_synth_ctrl_stop_logic #(.ROM_MULT(9'h123), .ROM_DIV(7'h2A))
    clock_synth_ctrl_stop_logic_inst (
    .clk_sys(clk_sys), .nrst(nrst), .cpu_clk(cpu_clk),
    .reg_idx(reg_idx), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .freq_strap(freq_strap),
    .early_pci_strap_hi(early_pci_strap_hi),
    .early_pci_strap_lo(early_pci_strap_lo),
    .cpu_halt_n(cpu_halt_n), .pci_halt_n(pci_halt_n),
    .mult_eff(mult_eff), .div_eff(div_eff), .scale_const(scale_const),
    .pci_adv_ps(pci_adv_ps), .spread_code(spread_code),
    .spread_center(spread_center), .spread_up(spread_up),
    .spread_down(spread_down), .dual_is_48m(dual_is_48m),
    .dual_spread_en(dual_spread_en), .align_48m(align_48m),
    .pci_run(pci_run), .cpu_stopped(cpu_stopped), .cpu_tri(cpu_tri));

  host_agent host_agent_inst (
    .clk_sys(clk_sys), .reg_idx(reg_idx), .reg_wr(reg_wr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .cpu_halt_n(cpu_halt_n), .pci_halt_n(pci_halt_n));

  // ------------------------------------------------------------
  // Shared helpers
  // ------------------------------------------------------------
  task automatic check(input string nm, input logic [31:0] seen,
                       input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic wrap_up();
    $display("checks %0d errors %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // Hang guard: whole run is a few hundred cycles
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      error_cnt++;
      wrap_up();
    end
  end

  // Straps set before release; caught once after it
  task automatic do_reset(input logic [1:0] fs, input logic hi,
                          input logic lo);
    @(posedge clk_sys);
    nrst <= 1'b0;
    freq_strap <= fs;
    early_pci_strap_hi <= hi;
    early_pci_strap_lo <= lo;
    repeat (2) @(posedge clk_sys);
    nrst <= 1'b1;
    repeat (5) @(posedge clk_sys);
    #1;
  endtask

  // Bounded poll: 0 stopped, 1 tri-state, 2 PCI running
  task automatic wait_on(input int sel, input logic [2:0] exp,
                         input string nm);
    logic [2:0] s;
    for (int n = 0; n < 10; n++) begin
      @(posedge clk_sys);
      #1;
      s = (sel == 0) ? cpu_stopped : (sel == 1) ? cpu_tri : {2'b00, pci_run};
      if (s === exp) break;
    end
    check(nm, s, exp);
  endtask

  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task automatic t_straps();
    logic [26:0] sc [4] = '{27'd32005333, 27'd48008000,
                            27'd96016000, 27'd64010667};
    logic [10:0] adv [4] = '{11'd0, 11'd0, 11'd800, 11'd1600};
    for (int i = 0; i < 4; i++) begin
      do_reset(i[1:0], i[1], i[0]);
      check("scale", scale_const, sc[i]);
      check("adv", pci_adv_ps, adv[i]);
    end
  endtask

  task automatic t_regs();
    host_agent_inst.rd(4'h6, rv);
    check("sig", rv, {SIG_REVISION, SIG_VENDOR});
    host_agent_inst.rd(4'h7, rv);
    check("b7", rv, 8'h0E);
    host_agent_inst.rd(4'h8, rv);
    check("b8", rv, 8'h00);
    host_agent_inst.rd(4'h9, rv);
    check("b9", rv, 8'h00);
    host_agent_inst.wr(4'h6, 8'hFF);
    host_agent_inst.wr(4'h7, 8'hFF);
    host_agent_inst.wr(4'h8, 8'hA5);
    host_agent_inst.wr(4'h9, 8'hB6);
    host_agent_inst.wr(4'hF, 8'hFF);
    host_agent_inst.rd(4'h6, rv);
    check("sig_ro", rv, {SIG_REVISION, SIG_VENDOR});
    host_agent_inst.rd(4'h7, rv);
    check("b7_wr", rv, 8'h0F);
    check("rom_mult", mult_eff, 9'h123);
    check("rom_div", div_eff, 7'h2A);
    host_agent_inst.wr(4'h9, 8'hB7);
    host_agent_inst.rd(4'hF, rv);
    check("unmapped", rv, 8'h00);
    check("bus_mult", mult_eff, 9'h1A5);
    check("bus_div", div_eff, 7'h5B);
    host_agent_inst.wr(4'h8, 8'h3C);
    host_agent_inst.rd(4'h8, rv);
    check("b8_rw", rv, 8'h3C);
    check("bus_mult2", mult_eff, 9'h13C);
  endtask

  task automatic t_spread();
    logic [7:0] dn [8] = '{8'd25, 8'd50, 8'd75, 8'd100,
                           8'd13, 8'd25, 8'd37, 8'd150};
    logic [7:0] up [8] = '{8'd0, 8'd0, 8'd0, 8'd0,
                           8'd13, 8'd25, 8'd37, 8'd50};
    for (int c = 0; c < 8; c++) begin
      host_agent_inst.wr(4'h4, {c[2], 7'h3F});
      host_agent_inst.wr(4'h5, {c[1:0], 6'h00});
      repeat (3) @(posedge clk_sys);
      #1;
      check("sp_code", spread_code, c[2:0]);
      check("sp_ctr", spread_center, c[2]);
      check("sp_dn", spread_down, dn[c]);
      check("sp_up", spread_up, up[c]);
    end
  endtask

  task automatic t_dual();
    check("d66", {dual_is_48m, dual_spread_en}, 2'b01);
    host_agent_inst.wr(4'h0, 8'h20);
    repeat (2) @(posedge clk_sys);
    #1;
    check("d48", {dual_is_48m, dual_spread_en}, 2'b10);
    check("align", align_48m, 1'b1);
  endtask

  task automatic t_cpu();
    host_agent_inst.halt(1'b0, 1'b1);
    @(negedge cpu_clk);
    #0.1;
    check("early", cpu_stopped, 3'b000);
    wait_on(0, 3'b111, "stop_all");
    check("drv", cpu_tri, 3'b000);
    check("others", {pci_run, dual_is_48m}, 2'b11);
    host_agent_inst.halt(1'b1, 1'b1);
    wait_on(0, 3'b000, "restart");
    host_agent_inst.wr(4'h1, 8'h0F);
    host_agent_inst.halt(1'b0, 1'b1);
    wait_on(0, 3'b110, "free0");
    host_agent_inst.halt(1'b1, 1'b1);
    wait_on(0, 3'b000, "restart2");
    host_agent_inst.wr(4'h1, 8'h47);
    host_agent_inst.halt(1'b0, 1'b1);
    wait_on(1, 3'b111, "tri_on");
    host_agent_inst.halt(1'b1, 1'b1);
    wait_on(1, 3'b000, "tri_off");
  endtask

  task automatic t_pci();
    host_agent_inst.halt(1'b1, 1'b0);
    wait_on(2, 3'b000, "pci_stop");
    host_agent_inst.halt(1'b1, 1'b1);
    wait_on(2, 3'b001, "pci_go");
  endtask

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    nrst = 1'b0;
    freq_strap = 2'b00;
    early_pci_strap_hi = 1'b0;
    early_pci_strap_lo = 1'b0;
    error_cnt = 0;
    check_count = 0;
    cyc = 0;
    t_straps();
    t_regs();
    t_spread();
    t_dual();
    t_cpu();
    t_pci();
    wrap_up();
  end
endmodule

// >>> test/host_agent.sv
`timescale 1ns/1ps
// ------------------------------------------------------------
// Host side: byte register master and stop-line driver
// ------------------------------------------------------------
module host_agent (
  // Clock
  input  wire logic       clk_sys,
  // Register port
  output logic [3:0]      reg_idx,
  output logic            reg_wr,
  output logic [7:0]      reg_wdata,
  input  wire logic [7:0] reg_rdata,
  // Stop lines
  output logic            cpu_halt_n,
  output logic            pci_halt_n
);
  // Idle bus, stop lines released
  initial begin
    reg_idx = 4'h0;
    reg_wr = 1'b0;
    reg_wdata = 8'h00;
    cpu_halt_n = 1'b1;
    pci_halt_n = 1'b1;
  end

  // One-cycle strobe; data scrambled after so nothing leans on it
  task automatic wr(input logic [3:0] idx, input logic [7:0] dat);
    @(posedge clk_sys);
    reg_idx <= idx;
    reg_wdata <= dat;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
    reg_wdata <= ~dat;
  endtask

  // Present index, take registered data once it has settled
  task automatic rd(input logic [3:0] idx, output logic [7:0] dat);
    @(posedge clk_sys);
    reg_idx <= idx;
    @(posedge clk_sys);
    @(posedge clk_sys);
    #1;
    dat = reg_rdata;
  endtask

  // Stop levels change just after an edge
  task automatic halt(input logic cpu_n, input logic pci_n);
    @(posedge clk_sys);
    cpu_halt_n <= cpu_n;
    pci_halt_n <= pci_n;
  endtask
endmodule
